//--- inc/facr_pkg.sv
// facr_pkg: constants for the fifo / auxiliary configuration register bank
package facr_pkg;
  // ****************************************
  // register indices (byte address = index * 4)
  // ****************************************
  localparam logic [9:0] IDX_AUX_POLL_CONFIG = 10'h044;
  localparam logic [9:0] IDX_FIFO_DOWNSAMPLE_CONFIG = 10'h045;
  localparam logic [9:0] IDX_FIFO_THRESHOLD_LOW = 10'h046;
  localparam logic [9:0] IDX_FIFO_THRESHOLD_HIGH = 10'h047;
  localparam logic [9:0] IDX_FIFO_MODE_CONFIG = 10'h048;
  localparam logic [9:0] IDX_FIFO_FRAME_SELECT = 10'h049;
  localparam logic [9:0] IDX_AUX_TARGET_ADDRESS = 10'h04B;
  localparam logic [9:0] IDX_FIFO_STATUS = 10'h050;
  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [7:0] RST_AUX_POLL_CONFIG = 8'h46;
  localparam logic [7:0] RST_FIFO_DOWNSAMPLE_CONFIG = 8'h80;
  localparam logic [7:0] RST_FIFO_THRESHOLD_LOW = 8'h00;
  localparam logic [7:0] RST_FIFO_THRESHOLD_HIGH = 8'h02;
  localparam logic [7:0] RST_FIFO_MODE_CONFIG = 8'h02;
  localparam logic [7:0] RST_FIFO_FRAME_SELECT = 8'h10;
  localparam logic [7:0] RST_AUX_TARGET_ADDRESS = 8'h20;
  localparam logic [7:0] MSK_AUX_POLL_CONFIG = 8'hFF;
  localparam logic [7:0] MSK_FIFO_DOWNSAMPLE_CONFIG = 8'hF0;
  localparam logic [7:0] MSK_FIFO_THRESHOLD_LOW = 8'hFF;
  localparam logic [7:0] MSK_FIFO_THRESHOLD_HIGH = 8'h1F;
  localparam logic [7:0] MSK_FIFO_MODE_CONFIG = 8'h03;
  localparam logic [7:0] MSK_FIFO_FRAME_SELECT = 8'h7C;
  localparam logic [7:0] MSK_AUX_TARGET_ADDRESS = 8'hFE;
  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_AUX_OFFSET = 4;
  localparam int POS_DOWNS = 4;
  localparam int POS_FILT_SEL = 7;
  localparam int POS_STOP_FULL = 0;
  localparam int POS_TIME_EN = 1;
  localparam int POS_ACC_EN = 6;
  localparam int POS_AUX_EN = 5;
  localparam int POS_HDR_EN = 4;
  localparam int POS_PIN_ONE_TAG = 3;
  localparam int POS_PIN_TWO_TAG = 2;
  // ****************************************
  // poll rate codes and frame headers
  // ****************************************
  localparam logic [3:0] ODR_CODE_MIN = 4'h1;
  localparam logic [3:0] ODR_CODE_MAX = 4'hB;
  localparam logic [7:0] HDR_ACC = 8'h84;
  localparam logic [7:0] HDR_AUX = 8'h88;
  localparam logic [7:0] HDR_TIME = 8'h44;
  localparam logic [4:0] BYTES_PAYLOAD = 5'h06;
  localparam logic [4:0] BYTES_WITH_HDR = 5'h07;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int POLL_BASE_US = 1280000; // period of the slowest rate, 25/32 Hz
  localparam int AUX_OFFSET_STEP_US = 2500; // 2.5 ms
  localparam int POLL_BASE_CYC = POLL_BASE_US * CLK_MHZ;
  localparam int AUX_OFFSET_STEP_CYC = AUX_OFFSET_STEP_US * CLK_MHZ;
  // ****************************************
  // data path sizes
  // ****************************************
  localparam int FRAME_W = 64;
  localparam int FIFO_DEPTH = 16;
endpackage

//--- core/fifo_aux_config_regs.sv
// fifo_aux_config_regs: fifo / auxiliary poll configuration bank with frame writer and fifo
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps

// ****************************************
// frame fifo
// ****************************************
module facr_fifo import facr_pkg::*; #(
  parameter int WIDTH = FRAME_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  input wire logic dropOldest,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] cnt;
  } facr_fifo_state_t;
  facr_fifo_state_t s_q, s_d;
  logic full, push, pop;

  // a full fifo accepts only when told to overwrite its oldest word
  assign full = (s_q.cnt == (AW+1)'(DEPTH));
  assign inReady = !full || dropOldest;
  assign outValid = (s_q.cnt != '0);
  assign outData = s_q.mem[s_q.rdPtr];
  assign level = s_q.cnt;
  assign push = inValid && inReady;
  assign pop = (outValid && outReady) || (push && full);

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wrPtr] = inData;
      s_d.wrPtr = s_q.wrPtr + AW'(1);
    end
    if (pop) begin
      s_d.rdPtr = s_q.rdPtr + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (rst) begin
      s_d.wrPtr = '0;
      s_d.rdPtr = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end
endmodule // facr_fifo

// ****************************************
// register bank, aux poll timer and frame writer
// ****************************************
module fifo_aux_config_regs import facr_pkg::*; #(
  parameter int POLL_BASE = POLL_BASE_CYC,
  parameter int OFFSET_STEP = AUX_OFFSET_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic accValid,
  input wire logic [47:0] accRawData,
  input wire logic [47:0] accFiltData,
  input wire logic auxValid,
  input wire logic [47:0] auxData,
  input wire logic [23:0] sensorTime,
  input wire logic irq_pin_one,
  input wire logic irq_pin_two,
  output logic auxTrigger,
  output logic auxReadout,
  output logic [6:0] auxTargetAddr,
  output logic frameValid,
  input wire logic frameReady,
  output logic [FRAME_W-1:0] frameData,
  output logic wmReached
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  typedef struct packed {
    logic [7:0] auxCfg;
    logic [7:0] downsCfg;
    logic [7:0] wmLow;
    logic [7:0] wmHigh;
    logic [7:0] modeCfg;
    logic [7:0] frameSel;
    logic [7:0] targetAddr;
    logic [25:0] pollCnt;
    logic [6:0] dsCnt;
    logic auxPend;
    logic [47:0] auxBuf;
    logic timePend;
    logic [1:0] pinOneSync;
    logic [1:0] pinTwoSync;
    logic trig;
    logic rdout;
    logic wm;
  } facr_state_t;
  facr_state_t s_q, s_d;

  logic [9:0] regIdx;
  logic mapped, wrStrobe;
  logic [7:0] rdByte;
  logic [3:0] odrCode;
  logic [3:0] offCode;
  logic odrOk;
  logic [25:0] period, offCyc, trigPoint;
  logic [6:0] dsMask;
  logic dsHit, accWr, auxWr;
  logic [7:0] hdrByte, tagByte;
  logic [47:0] payload;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoPush, fifoPop;
  logic [FRAME_W-1:0] fifoInData, fifoOutData;
  logic [LW-1:0] level;
  logic [12:0] wmLevel;
  logic [12:0] fillBytes;

  // ****************************************
  // apb slave: zero wait states, error on unmapped or misaligned
  // ****************************************
  assign regIdx = paddr[11:2];
  assign pready = 1'b1;
  assign wrStrobe = psel && penable && pwrite && mapped;
  assign pslverr = psel && penable && !mapped;
  assign prdata = {24'h000000, mapped ? rdByte : 8'h00};

  always_comb begin
    mapped = (paddr[1:0] == 2'h0);
    rdByte = 8'h00;
    unique case (regIdx)
      IDX_AUX_POLL_CONFIG: rdByte = s_q.auxCfg;
      IDX_FIFO_DOWNSAMPLE_CONFIG: rdByte = s_q.downsCfg;
      IDX_FIFO_THRESHOLD_LOW: rdByte = s_q.wmLow;
      IDX_FIFO_THRESHOLD_HIGH: rdByte = s_q.wmHigh;
      IDX_FIFO_MODE_CONFIG: rdByte = s_q.modeCfg;
      IDX_FIFO_FRAME_SELECT: rdByte = s_q.frameSel;
      IDX_AUX_TARGET_ADDRESS: rdByte = s_q.targetAddr;
      IDX_FIFO_STATUS: rdByte = {s_q.wm, !fifoInReady, s_q.timePend, level};
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************
  // aux poll timer
  // ****************************************
  assign odrCode = s_q.auxCfg[3:0];
  assign offCode = s_q.auxCfg[POS_AUX_OFFSET +: 4];
  assign odrOk = (odrCode >= ODR_CODE_MIN) && (odrCode <= ODR_CODE_MAX);
  assign period = 26'(POLL_BASE) >> (odrCode - ODR_CODE_MIN);
  assign offCyc = 26'(offCode) * 26'(OFFSET_STEP);
  // the trigger lands offCyc ahead of the readout; a zero offset, or one at least as long as the period,
  // goes to the cycle right after the previous readout
  always_comb begin
    if (offCode == 4'h0 || offCyc >= period) begin
      trigPoint = 26'h0;
    end else begin
      trigPoint = period - 26'h1 - offCyc;
    end
  end
  assign auxTrigger = s_q.trig;
  assign auxReadout = s_q.rdout;
  assign auxTargetAddr = s_q.targetAddr[7:1];

  // ****************************************
  // frame writer
  // ****************************************
  assign dsMask = 7'((8'h01 << s_q.downsCfg[POS_DOWNS +: 3]) - 8'h01);
  assign dsHit = ((s_q.dsCnt & dsMask) == 7'h00);
  assign accWr = accValid && s_q.frameSel[POS_ACC_EN] && dsHit;
  assign auxWr = s_q.auxPend && !accWr;
  assign fifoInValid = accWr || auxWr;
  always_comb begin
    if (accWr) begin
      payload = s_q.downsCfg[POS_FILT_SEL] ? accFiltData : accRawData;
      hdrByte = HDR_ACC;
    end else begin
      payload = s_q.auxBuf;
      hdrByte = HDR_AUX;
    end
    if (!s_q.frameSel[POS_HDR_EN]) begin
      hdrByte = 8'h00;
    end
    tagByte = 8'h00;
    tagByte[1] = s_q.frameSel[POS_PIN_TWO_TAG] && s_q.pinTwoSync[1];
    tagByte[0] = s_q.frameSel[POS_PIN_ONE_TAG] && s_q.pinOneSync[1];
  end
  assign fifoInData = {hdrByte, tagByte, payload};
  assign fifoPush = fifoInValid && fifoInReady;

  facr_fifo #(
    .WIDTH(FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) i_facr_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .dropOldest(!s_q.modeCfg[POS_STOP_FULL]),
    .outValid(fifoOutValid),
    .outReady(frameReady),
    .outData(fifoOutData),
    .level(level)
  );

  // ****************************************
  // readout side and watermark
  // ****************************************
  assign frameValid = fifoOutValid || s_q.timePend;
  assign frameData = fifoOutValid ? fifoOutData :
    {(s_q.frameSel[POS_HDR_EN] ? HDR_TIME : 8'h00), 32'h00000000, sensorTime};
  assign fifoPop = fifoOutValid && frameReady;
  assign wmLevel = {s_q.wmHigh[4:0], s_q.wmLow};
  assign fillBytes = 13'(level) *
    13'(s_q.frameSel[POS_HDR_EN] ? BYTES_WITH_HDR : BYTES_PAYLOAD);
  assign wmReached = s_q.wm;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.pinOneSync = {s_q.pinOneSync[0], irq_pin_one};
    s_d.pinTwoSync = {s_q.pinTwoSync[0], irq_pin_two};
    s_d.wm = (fillBytes >= wmLevel);
    // poll timer stops on a reserved rate code
    s_d.trig = 1'b0;
    s_d.rdout = 1'b0;
    if (!odrOk) begin
      s_d.pollCnt = 26'h0;
    end else begin
      s_d.trig = (s_q.pollCnt == trigPoint);
      if (s_q.pollCnt >= period - 26'h1) begin
        s_d.pollCnt = 26'h0;
        s_d.rdout = 1'b1;
      end else begin
        s_d.pollCnt = s_q.pollCnt + 26'h1;
      end
    end
    if (accValid && s_q.frameSel[POS_ACC_EN]) begin
      s_d.dsCnt = s_q.dsCnt + 7'h01;
    end
    // one-deep aux holding slot; a newer sample replaces an unwritten one
    if (auxWr && fifoPush) begin
      s_d.auxPend = 1'b0;
    end
    if (auxValid && s_q.frameSel[POS_AUX_EN]) begin
      s_d.auxPend = 1'b1;
      s_d.auxBuf = auxData;
    end
    if (!fifoOutValid && s_q.timePend && frameReady) begin
      s_d.timePend = 1'b0;
    end
    if (fifoPop && level == LW'(1) && !fifoPush && s_q.modeCfg[POS_TIME_EN]) begin
      s_d.timePend = 1'b1;
    end
    if (wrStrobe) begin
      unique case (regIdx)
        IDX_AUX_POLL_CONFIG: s_d.auxCfg = pwdata[7:0] & MSK_AUX_POLL_CONFIG;
        IDX_FIFO_DOWNSAMPLE_CONFIG: s_d.downsCfg = pwdata[7:0] & MSK_FIFO_DOWNSAMPLE_CONFIG;
        IDX_FIFO_THRESHOLD_LOW: s_d.wmLow = pwdata[7:0] & MSK_FIFO_THRESHOLD_LOW;
        IDX_FIFO_THRESHOLD_HIGH: s_d.wmHigh = pwdata[7:0] & MSK_FIFO_THRESHOLD_HIGH;
        IDX_FIFO_MODE_CONFIG: s_d.modeCfg = pwdata[7:0] & MSK_FIFO_MODE_CONFIG;
        IDX_FIFO_FRAME_SELECT: s_d.frameSel = pwdata[7:0] & MSK_FIFO_FRAME_SELECT;
        IDX_AUX_TARGET_ADDRESS: s_d.targetAddr = pwdata[7:0] & MSK_AUX_TARGET_ADDRESS;
        default: s_d.auxCfg = s_q.auxCfg;
      endcase
    end
    if (rst) begin
      s_d = '0;
      s_d.auxCfg = RST_AUX_POLL_CONFIG;
      s_d.downsCfg = RST_FIFO_DOWNSAMPLE_CONFIG;
      s_d.wmLow = RST_FIFO_THRESHOLD_LOW;
      s_d.wmHigh = RST_FIFO_THRESHOLD_HIGH;
      s_d.modeCfg = RST_FIFO_MODE_CONFIG;
      s_d.frameSel = RST_FIFO_FRAME_SELECT;
      s_d.targetAddr = RST_AUX_TARGET_ADDRESS;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RSVD_ZERO: assert property (
    psel && penable && regIdx == IDX_FIFO_MODE_CONFIG && paddr[1:0] == 2'h0
      |-> prdata[31:2] == 30'h0)
    else $error("reserved mode bits read nonzero");
  AST_ADDR_BIT0: assert property (
    wrStrobe && regIdx == IDX_AUX_TARGET_ADDRESS
      |=> s_q.targetAddr == {$past(pwdata[7:1]), 1'b0}
        && auxTargetAddr == $past(pwdata[7:1]))
    else $error("aux target address not stored correctly");
  AST_UNMAPPED_ZERO: assert property (
    pslverr |-> prdata == 32'h00000000)
    else $error("refused access returned nonzero read data");
  AST_POLL_RSVD: assert property (
    !odrOk [*2] |-> !auxReadout && !auxTrigger)
    else $error("poll pulse on reserved rate code");
  AST_ZERO_OFFSET: assert property (
    odrOk && offCode == 4'h0 && $stable(s_q.auxCfg) && auxReadout |=> auxTrigger)
    else $error("trigger not right after readout with zero offset");
  AST_STOP_FULL: assert property (
    s_q.modeCfg[POS_STOP_FULL] && level == LW'(FIFO_DEPTH) && !frameReady
      |=> level == LW'(FIFO_DEPTH) && $stable(fifoOutData))
    else $error("full fifo changed while stop-on-full set");
  AST_NO_ACC: assert property (
    !s_q.frameSel[POS_ACC_EN] |-> !accWr)
    else $error("acc frame written while disabled");
  AST_NO_AUX: assert property (
    !s_q.frameSel[POS_AUX_EN] && !s_q.auxPend |=> !s_q.auxPend)
    else $error("aux sample held while disabled");
  AST_HDR_OFF: assert property (
    fifoPush && !s_q.frameSel[POS_HDR_EN] |-> fifoInData[63:56] == 8'h00)
    else $error("header stored in headerless mode");
  AST_TIME_OFF: assert property (
    !s_q.modeCfg[POS_TIME_EN] && !s_q.timePend |=> !s_q.timePend)
    else $error("time frame raised while disabled");
  AST_WM: assert property (
    $stable(level) && $stable(wmLevel) && $stable(s_q.frameSel) |=>
      wmReached == (13'($past(level)) * ($past(s_q.frameSel[POS_HDR_EN]) ?
        13'(BYTES_WITH_HDR) : 13'(BYTES_PAYLOAD)) >= $past(wmLevel)))
    else $error("watermark flag wrong");
  AST_DOWNS: assert property (
    accWr && s_q.downsCfg[POS_DOWNS +: 3] != 3'h0 |-> !s_q.dsCnt[0])
    else $error("odd acc sample stored while downsampling");

  COV_FULL: cover property (level == LW'(FIFO_DEPTH) && fifoInValid);
  COV_TIME: cover property (frameValid && !fifoOutValid && frameReady);
  COV_POLL: cover property (auxTrigger ##[1:200] auxReadout);
  COV_WM: cover property ($rose(wmReached));
endmodule // fifo_aux_config_regs

//--- tb/facr_aux_sensor.sv
// facr_aux_sensor: behavioural auxiliary sensor that answers each readout with one sample unless another readout arrives before the sample is out
`timescale 1ns/10ps
module facr_aux_sensor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic auxReadout,
  input wire logic slow,
  output logic auxValid = 1'b0,
  output logic [47:0] auxData = 48'h0
);
  logic [2:0] waitQ = 3'h0;
  logic busyQ = 1'b0;
  logic [47:0] sampleQ = 48'h1234_5678_9ABC;
  always @(posedge ref_clk) begin
    auxValid <= 1'b0;
    // no sample on the lines: keep them moving so stale data never passes as fresh
    auxData <= ~auxData;
    if (rst) begin
      busyQ <= 1'b0;
    end else if (auxReadout) begin
      busyQ <= 1'b1;
      waitQ <= slow ? 3'h5 : 3'h0;
    end else if (busyQ) begin
      waitQ <= waitQ - 3'h1;
      if (waitQ == 3'h0) begin
        auxValid <= 1'b1;
        auxData <= sampleQ;
        sampleQ <= sampleQ + 48'h0101_0101_0101;
        busyQ <= 1'b0;
      end
    end
  end
endmodule // facr_aux_sensor

//--- tb/tb_fifo_aux_config_regs.sv
// tb_fifo_aux_config_regs: self-checking bench for the fifo / aux configuration bank
`timescale 1ns/10ps
module tb_fifo_aux_config_regs import facr_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, auxValid, auxTrigger, auxReadout, frameValid, wmReached;
  logic accValid = 1'b0;
  logic irqOne = 1'b0;
  logic irqTwo = 1'b0;
  logic auxSlow = 1'b0;
  logic frameReady = 1'b0;
  logic [47:0] accRaw = 48'h0;
  logic [47:0] accFilt = 48'h0;
  logic [47:0] auxData;
  logic [23:0] sensorTime = 24'h0;
  logic [6:0] auxTargetAddr;
  logic [63:0] frameData;
  logic [63:0] expQ[$];
  logic [7:0] rstV [7] = '{8'h46, 8'h80, 8'h00, 8'h02, 8'h02, 8'h10, 8'h20};
  logic [7:0] mskV [7] = '{8'hFF, 8'hF0, 8'hFF, 8'h1F, 8'h03, 8'h7C, 8'hFE};
  int badCount = 0;
  int checkCount = 0;
  int cyc = 0;
  int seed = 32'h4202;
  bit hold = 1'b1;
  bit auxNote = 1'b0;

  always #20 ref_clk = ~ref_clk;

  // short poll base keeps the slowest rate at 1024 cycles
  fifo_aux_config_regs #(.POLL_BASE(1024), .OFFSET_STEP(16)) i_fifo_aux_config_regs (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accValid(accValid), .accRawData(accRaw), .accFiltData(accFilt), .auxValid(auxValid),
    .auxData(auxData), .sensorTime(sensorTime), .irq_pin_one(irqOne), .irq_pin_two(irqTwo),
    .auxTrigger(auxTrigger), .auxReadout(auxReadout), .auxTargetAddr(auxTargetAddr),
    .frameValid(frameValid), .frameReady(frameReady), .frameData(frameData),
    .wmReached(wmReached));
  facr_aux_sensor i_facr_aux_sensor (.ref_clk(ref_clk), .rst(rst), .auxReadout(auxReadout),
    .slow(auxSlow), .auxValid(auxValid), .auxData(auxData));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d, errors %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the bench timeout ends a hung access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, {idx, 2'b00}, {24'h0, d}, rd, err);
  endtask
  task automatic pushAcc(input logic [47:0] raw, input logic [47:0] filt, input bit note,
                         input logic [7:0] hdr, input logic [7:0] tags, input bit useFilt);
    @(posedge ref_clk);
    accValid <= 1'b1;
    accRaw <= raw;
    accFilt <= filt;
    if (note) expQ.push_back({hdr, tags, useFilt ? filt : raw});
    @(posedge ref_clk);
    accValid <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    hold = 1'b0;
    while ((expQ.size() != 0 || frameValid !== 1'b0) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) badCount++;
    repeat (4) @(posedge ref_clk);
    check(expQ.size(), 0);
    hold = 1'b1;
  endtask
  task automatic waitP(input bit trig, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((trig ? auxTrigger : auxReadout) !== 1'b1 && n < 3000);
    if (n >= 3000) badCount++;
  endtask
  task automatic poll(input logic [7:0] cfg, input int gap, input int period);
    int n;
    wr(IDX_AUX_POLL_CONFIG, cfg);
    waitP(1'b0, n);
    waitP(1'b1, n);
    waitP(1'b0, n);
    check(n, gap);
    waitP(1'b0, n);
    check(n, period);
  endtask

  // ****************************************
  // stimulus and monitors
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    frameReady <= !hold && ($random(seed) & 1);
    if (auxNote && auxValid === 1'b1) expQ.push_back({HDR_AUX, 8'h00, auxData});
    if (frameValid === 1'b1 && frameReady === 1'b1) begin
      if (expQ.size() == 0) check(1'b1, 1'b0);
      else check(frameData, expQ.pop_front());
    end
    if (cyc == 40000) begin
      badCount++;
      printVerdict();
    end
  end

  initial begin
    logic [31:0] rd;
    logic [31:0] wd;
    logic [11:0] a;
    logic err;
    logic [47:0] r;
    int n;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      a = 12'h110 + 12'(4 * i) + (i == 6 ? 12'h004 : 12'h000);
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, {24'h0, rstV[i]});
      wd = $random(seed);
      if (i == 5) wd[5] = 1'b0;
      apb(1'b1, a, wd, rd, err);
      check(err, 1'b0);
      apb(1'b0, a, 32'h0, rd, err);
      check(rd, {24'h0, wd[7:0] & mskV[i]});
    end
    check(auxTargetAddr, wd[7:1]);
    for (int i = 0; i < 12; i++) begin
      apb(1'(i % 2), i < 6 ? 12'h128 : 12'h111, 32'hFF, rd, err);
      check({err, rd}, {1'b1, 32'h0});
    end
    wr(IDX_FIFO_MODE_CONFIG, 8'h00);
    wr(IDX_FIFO_FRAME_SELECT, 8'h50);
    wr(IDX_FIFO_DOWNSAMPLE_CONFIG, 8'hA0);
    wr(IDX_FIFO_THRESHOLD_HIGH, 8'h1F);
    foreach (rstV[i]) begin
      if (i > 2) continue;
      wr(IDX_AUX_POLL_CONFIG, i == 0 ? 8'h00 : (i == 1 ? 8'h0C : 8'hFF));
      repeat (40) @(posedge ref_clk);
      n = 0;
      repeat (300) begin
        @(posedge ref_clk);
        if (auxReadout === 1'b1 || auxTrigger === 1'b1) n++;
      end
      check(n, 0);
    end
    for (int i = 0; i < 8; i++) begin
      pushAcc({16'($random(seed)), $random(seed)}, {16'($random(seed)), $random(seed)},
              i % 4 == 0, HDR_ACC, 8'h00, 1'b1);
    end
    drain();
    wr(IDX_FIFO_DOWNSAMPLE_CONFIG, 8'h00);
    for (int t = 0; t < 3; t++) begin
      wr(IDX_FIFO_FRAME_SELECT, t < 2 ? 8'h5C : 8'h50);
      irqOne <= 1'b1;
      irqTwo <= t > 0;
      repeat (4) @(posedge ref_clk);
      pushAcc({16'($random(seed)), $random(seed)}, {16'($random(seed)), $random(seed)}, 1'b1,
              HDR_ACC, t == 0 ? 8'h01 : (t == 1 ? 8'h03 : 8'h00), 1'b0);
    end
    drain();
    for (int h = 1; h >= 0; h--) begin
      wr(IDX_FIFO_FRAME_SELECT, h ? 8'h50 : 8'h40); // only acc stored, one rate
      wr(IDX_FIFO_THRESHOLD_LOW, h ? 8'd21 : 8'd18);
      wr(IDX_FIFO_THRESHOLD_HIGH, 8'h00);
      for (int k = 0; k < 3; k++) begin
        pushAcc({16'($random(seed)), $random(seed)}, 48'h0, 1'b1, h ? HDR_ACC : 8'h00, 8'h00,
                1'b0);
        repeat (3) @(posedge ref_clk);
        check(wmReached, k == 2);
      end
      drain();
    end
    for (int s = 1; s >= 0; s--) begin
      wr(IDX_FIFO_MODE_CONFIG, 8'(s));
      wr(IDX_FIFO_FRAME_SELECT, 8'h50);
      for (int k = 0; k < 18; k++) begin
        pushAcc({16'($random(seed)), $random(seed)}, 48'h0, s ? k < 16 : k >= 2, HDR_ACC,
                8'h00, 1'b0);
      end
      apb(1'b0, 12'h140, 32'h0, rd, err);
      check(rd, s ? 32'hD0 : 32'h90);
      drain();
    end
    wr(IDX_FIFO_MODE_CONFIG, 8'h02);
    sensorTime <= 24'($random(seed));
    r = {16'($random(seed)), $random(seed)};
    pushAcc(r, 48'h0, 1'b1, HDR_ACC, 8'h00, 1'b0);
    expQ.push_back({HDR_TIME, 32'h0, sensorTime});
    drain();
    wr(IDX_FIFO_MODE_CONFIG, 8'h00);
    wr(IDX_FIFO_FRAME_SELECT, 8'h30);
    auxNote = 1'b1;
    wr(IDX_AUX_POLL_CONFIG, 8'h06);
    hold = 1'b0;
    for (int k = 0; k < 4; k++) begin
      auxSlow <= k[0];
      pushAcc(r, r, 1'b0, HDR_ACC, 8'h00, 1'b0); // acc disabled, nothing stored
      repeat (100) @(posedge ref_clk);
    end
    wr(IDX_AUX_POLL_CONFIG, 8'h00);
    repeat (20) @(posedge ref_clk);
    auxNote = 1'b0;
    drain();
    poll(8'hF1, 240, 1024);
    poll(8'h16, 16, 32);
    poll(8'h06, 31, 32);
    poll(8'h0A, 1, 2);
    printVerdict();
  end
endmodule // tb_fifo_aux_config_regs
